// *** core/lcdma_pkg.sv ***
// Package with constants and types for the character display memory and addressing core.
package lcdma_pkg;

   // ***************************************************************
   // Register map and fields
   // ***************************************************************
   localparam logic [3:0] REG_INSTR = 4'h0;
   localparam logic [3:0] REG_DATA = 4'h4;
   localparam logic [3:0] REG_CTRL = 4'h8;
   localparam int CTRL_TWO_LINE = 0;
   localparam int CTRL_INC = 1;
   localparam int CTRL_CURSOR = 2;
   localparam int CTRL_BLINK = 3;
   localparam int CTRL_I2C = 4;
   localparam logic [7:0] CTRL_RESET = 8'h03;
   localparam int STAT_BUSY_BIT = 7;

   // ***************************************************************
   // Address-setting and display-shift instruction codes
   // ***************************************************************
   localparam int INS_CHAR_BIT = 7;
   localparam logic [1:0] INS_GLYPH_TOP = 2'h1;
   localparam logic [3:0] INS_ICON_TOP = 4'h2;
   localparam logic [6:0] INS_SHIFT_TOP = 7'h0C;

   // ***************************************************************
   // Memory geometry
   // ***************************************************************
   localparam int DD_DEPTH = 80;
   localparam int CG_DEPTH = 64;
   localparam int ICON_DEPTH = 16;
   localparam logic [6:0] LINE1_END = 7'h27;
   localparam logic [6:0] LINE2_BASE = 7'h40;
   localparam logic [6:0] LINE2_END = 7'h67;
   localparam logic [6:0] ONE_END = 7'h4F;
   localparam logic [6:0] LINE_LEN = 7'h28;
   localparam logic [6:0] ONE_LEN = 7'h50;
   localparam logic [6:0] LINE2_GAP = 7'h18;

   // ***************************************************************
   // Panel scan geometry
   // ***************************************************************
   localparam int COMMONS = 17;
   localparam int SEGS = 80;
   localparam logic [3:0] VIS_LAST = 4'hF;
   localparam logic [2:0] DOT_LAST = 3'h4;
   localparam logic [2:0] CURSOR_ROW = 3'h7;
   localparam logic [4:0] ICON_COM = 5'h10;
   localparam logic [4:0] FULL_ROW = 5'h1F;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_NS = 5;
   localparam int BUSY_NS = 40;
   localparam logic [7:0] BUSY_CYCLES = 8'((BUSY_NS + CLK_NS - 1) / CLK_NS);

   // Fixed glyph counts selected by the option pins 00, 01, 10, 11.
   localparam logic [8:0] GLYPH_CNT0 = 9'h0F0;
   localparam logic [8:0] GLYPH_CNT1 = 9'h0FA;
   localparam logic [8:0] GLYPH_CNT2 = 9'h0F8;
   localparam logic [8:0] GLYPH_CNT3 = 9'h100;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {TGT_CHAR, TGT_GLYPH, TGT_ICON} lcdma_target_t;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } lcdma_avreq_t;

   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } lcdma_avrsp_t;

   typedef struct packed {
      logic [DD_DEPTH-1:0][7:0] charMem;
      logic [CG_DEPTH-1:0][7:0] glyphMem;
      logic [ICON_DEPTH-1:0][4:0] iconMem;
      logic [6:0] ptr;
      lcdma_target_t target;
      logic [7:0] ctrl;
      logic [6:0] shiftOff;
      logic [7:0] busyCnt;
      logic rspRdy;
      logic [31:0] rdata;
      logic [2:0][1:0] optSync;
      logic [1:0] glyphOpt;
      logic [4:0] comIdx;
      logic [3:0] posIdx;
      logic [2:0] dotIdx;
      logic [SEGS-1:0] segShift;
      logic [SEGS-1:0] segHold;
      logic [COMMONS-1:0] comSel;
      logic [3:0] frameCnt;
   } lcdma_state_t;

endpackage

// *** core/lcdma_core.sv ***
// Display memory, address pointer, host register slave and panel scan of the character display core.
//
// Behaviour
// RULE_01 - Busy holds off new instructions until done.
// RULE_02 - Status read shows busy on bit seven.
// RULE_03 - Host polls busy before each next instruction.
// RULE_04 - Pointer loads from the instruction register.
// RULE_05 - Pointer steps by one after data access.
// RULE_06 - Status read shows pointer on bits 0-6.
// RULE_07 - Character memory holds eighty byte entries.
// RULE_08 - One-line mode shows sixteen from head.
// RULE_09 - Two-line mode maps 00-27 and 40-67.
// RULE_10 - Unshifted panel shows 00-0F and 40-4F.
// RULE_11 - Display shift moves window one, wrapping.
// RULE_12 - Fixed glyphs 5x8, count chosen by pins.
// RULE_13 - Host-writable user glyph memory, eight glyphs.
// RULE_14 - Host-writable icon memory drives eighty dots.
// RULE_15 - Scan reads and host access kept separate.
// RULE_16 - Serial host mode gives no read path; the control register still reads back.
// RULE_17 - Seventeen commons, eighty segments, one common.
// RULE_18 - Serial segment latch then holding latch.
// RULE_19 - Cursor or blink at pointer address.
// RULE_20 - Code bits 0-2 select user glyph.
// RULE_21 - Codes with zero upper nibble use user glyphs.
// RULE_22 - Eighth row is ORed with cursor.
// RULE_23 - Data goes to last addressed memory.
`timescale 1ns/1ps
module lcdma_core
   import lcdma_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire lcdma_pkg::lcdma_avreq_t avReq,
   output lcdma_pkg::lcdma_avrsp_t avRsp,
   input wire logic [1:0] glyphOptPins,
   output logic [lcdma_pkg::COMMONS-1:0] comOut,
   output logic [lcdma_pkg::SEGS-1:0] segOut
);
   import lcdma_pkg::*;

   lcdma_state_t s;
   lcdma_state_t next_s;
   logic reqValid;
   logic hostReg;
   logic blocked;
   logic done;
   logic twoLine;
   logic serialMode;
   logic [7:0] wByte;
   logic line2;
   logic [2:0] row;
   logic [6:0] col;
   logic [6:0] visAddr;
   logic [6:0] visIdx;
   logic [7:0] code;
   logic [4:0] pat;
   logic [8:0] glyphCnt;
   logic hit;
   logic pixel;
   logic transfer;
   logic [2:0] bitSel;

   // ***************************************************************
   // Helper functions
   // ***************************************************************

   // Maps a character address to its storage slot; line two sits above line one.
   function automatic logic [6:0] charIndex(input logic [6:0] a, input logic two);
      charIndex = (two && a >= LINE2_BASE) ? 7'(a - LINE2_GAP) : a;
   endfunction

   // Steps the pointer by one inside the range of the addressed memory.
   function automatic logic [6:0] stepPtr(input logic [6:0] p, input lcdma_target_t t, input logic inc,
                                         input logic two);
      logic [6:0] r;
      r = inc ? 7'(p + 7'h01) : 7'(p - 7'h01);
      unique case (t)
         TGT_CHAR:
         begin
            if (two)
            begin
               if (inc && p == LINE1_END) r = LINE2_BASE;
               else if (inc && p == LINE2_END) r = 7'h00;
               else if (!inc && p == LINE2_BASE) r = LINE1_END;
               else if (!inc && p == 7'h00) r = LINE2_END;
            end
            else
            begin
               if (inc && p == ONE_END) r = 7'h00;
               else if (!inc && p == 7'h00) r = ONE_END;
            end
         end
         TGT_GLYPH: r = {1'b0, r[5:0]};
         TGT_ICON: r = {3'h0, r[3:0]};
         default: r = 7'h00;
      endcase
      stepPtr = r;
   endfunction

   // Stand-in fixed glyph table; a mask table replaces it in silicon.
   function automatic logic [4:0] fixedRow(input logic [7:0] c, input logic [2:0] r);
      fixedRow = c[7:3] ^ {2'h0, r};
   endfunction

   // ***************************************************************
   // Host side decode
   // ***************************************************************

   // Waitrequest falls one cycle after a request unless an instruction or data write meets busy.
   assign reqValid = avReq.read || avReq.write;
   assign hostReg = (avReq.address == REG_INSTR) || (avReq.address == REG_DATA);
   assign blocked = avReq.write && hostReg && (s.busyCnt != 8'h00); // [RULE_01]
   assign done = reqValid && s.rspRdy;
   assign twoLine = s.ctrl[CTRL_TWO_LINE];
   assign serialMode = s.ctrl[CTRL_I2C];
   assign wByte = avReq.writedata[7:0];
   assign avRsp.waitrequest = reqValid && !s.rspRdy;
   assign avRsp.readdata = s.rdata;
   assign comOut = s.comSel;
   assign segOut = s.segHold;

   // ***************************************************************
   // Panel scan datapath
   // ***************************************************************

   // Scan reads its own address each cycle, independent of host cycles.
   always_comb
   begin
      line2 = s.comIdx[3];
      row = s.comIdx[2:0];
      col = 7'(s.posIdx) + s.shiftOff; // [RULE_11]
      if (twoLine && col >= LINE_LEN) col = 7'(col - LINE_LEN); // [RULE_11]
      else if (!twoLine && col >= ONE_LEN) col = 7'(col - ONE_LEN);
      visAddr = (twoLine && line2) ? 7'(LINE2_BASE + col) : col; // [RULE_09] [RULE_10]
      visIdx = (twoLine && line2) ? 7'(col + LINE_LEN) : col;
      code = s.charMem[visIdx]; // [RULE_15]
      unique case (s.glyphOpt)
         2'h0: glyphCnt = GLYPH_CNT0;
         2'h1: glyphCnt = GLYPH_CNT1;
         2'h2: glyphCnt = GLYPH_CNT2;
         2'h3: glyphCnt = GLYPH_CNT3;
      endcase
      if (code[7:4] == 4'h0) pat = s.glyphMem[{code[2:0], row}][4:0]; // [RULE_20] [RULE_21]
      else if ({1'b0, code} < glyphCnt) pat = fixedRow(code, row); // [RULE_12]
      else pat = 5'h00;
      hit = (s.target == TGT_CHAR) && (visAddr == s.ptr); // [RULE_19]
      if (hit && s.ctrl[CTRL_CURSOR] && row == CURSOR_ROW) pat = pat | FULL_ROW; // [RULE_22]
      if (hit && s.ctrl[CTRL_BLINK] && s.frameCnt[3]) pat = FULL_ROW; // [RULE_19]
      bitSel = 3'(DOT_LAST - s.dotIdx);
      if (s.comIdx == ICON_COM) pixel = s.iconMem[s.posIdx][bitSel]; // [RULE_14]
      else if (!twoLine && line2) pixel = 1'b0; // [RULE_08]
      else pixel = pat[bitSel];
      transfer = (s.posIdx == VIS_LAST) && (s.dotIdx == DOT_LAST);
   end

   // ***************************************************************
   // Next state
   // ***************************************************************

   // Computes the whole next state: pins, busy, bus answers, memories and scan.
   always_comb
   begin
      next_s = s;
      next_s.optSync[0] = glyphOptPins;
      next_s.optSync[1] = s.optSync[0];
      next_s.optSync[2] = s.optSync[1];
      if (s.optSync[1] == s.optSync[2]) next_s.glyphOpt = s.optSync[2];
      if (s.busyCnt != 8'h00) next_s.busyCnt = 8'(s.busyCnt - 8'h01); // [RULE_01]
      next_s.rspRdy = reqValid && !s.rspRdy && !blocked;
      if (reqValid && !s.rspRdy)
      begin
         next_s.rdata = 32'h0000_0000;
         if (avReq.address == REG_CTRL) next_s.rdata[7:0] = s.ctrl;
         else if (serialMode) next_s.rdata = 32'h0000_0000; // [RULE_16]
         else if (avReq.address == REG_INSTR)
         begin
            next_s.rdata[STAT_BUSY_BIT] = (s.busyCnt != 8'h00); // [RULE_02]
            next_s.rdata[6:0] = s.ptr; // [RULE_06]
         end
         else if (avReq.address == REG_DATA)
         begin
            unique case (s.target)
               TGT_CHAR: next_s.rdata[7:0] = s.charMem[charIndex(s.ptr, twoLine)];
               TGT_GLYPH: next_s.rdata[7:0] = s.glyphMem[s.ptr[5:0]];
               TGT_ICON: next_s.rdata[4:0] = s.iconMem[s.ptr[3:0]];
               default: next_s.rdata = 32'h0000_0000;
            endcase
         end
      end
      // Writes take effect only at the completing edge.
      if (done && avReq.write)
      begin
         if (avReq.address == REG_CTRL) next_s.ctrl = wByte;
         else if (avReq.address == REG_INSTR)
         begin
            next_s.busyCnt = BUSY_CYCLES; // [RULE_01]
            if (wByte[INS_CHAR_BIT])
            begin
               next_s.ptr = wByte[6:0]; // [RULE_04]
               next_s.target = TGT_CHAR; // [RULE_23]
            end
            else if (wByte[7:6] == INS_GLYPH_TOP)
            begin
               next_s.ptr = {1'b0, wByte[5:0]}; // [RULE_04]
               next_s.target = TGT_GLYPH; // [RULE_23]
            end
            else if (wByte[7:4] == INS_ICON_TOP)
            begin
               next_s.ptr = {3'h0, wByte[3:0]}; // [RULE_04]
               next_s.target = TGT_ICON; // [RULE_23]
            end
            else if (wByte[7:1] == INS_SHIFT_TOP)
            begin
               if (!wByte[0]) next_s.shiftOff = (s.shiftOff == 7'((twoLine ? LINE_LEN : ONE_LEN) - 7'h01))
                                                ? 7'h00 : 7'(s.shiftOff + 7'h01); // [RULE_11]
               else next_s.shiftOff = (s.shiftOff == 7'h00)
                                      ? 7'((twoLine ? LINE_LEN : ONE_LEN) - 7'h01) : 7'(s.shiftOff - 7'h01);
            end
         end
         else if (avReq.address == REG_DATA)
         begin
            next_s.busyCnt = BUSY_CYCLES;
            unique case (s.target)
               TGT_CHAR: next_s.charMem[charIndex(s.ptr, twoLine)] = wByte; // [RULE_07] [RULE_23]
               TGT_GLYPH: next_s.glyphMem[s.ptr[5:0]] = wByte; // [RULE_13]
               TGT_ICON: next_s.iconMem[s.ptr[3:0]] = wByte[4:0]; // [RULE_14]
               default: next_s.busyCnt = BUSY_CYCLES;
            endcase
            next_s.ptr = stepPtr(s.ptr, s.target, s.ctrl[CTRL_INC], twoLine); // [RULE_05]
         end
      end
      if (done && avReq.read && avReq.address == REG_DATA && !serialMode)
         next_s.ptr = stepPtr(s.ptr, s.target, s.ctrl[CTRL_INC], twoLine); // [RULE_05]
      // Serial segment shift, then parallel move into the holding latch.
      next_s.segShift = {s.segShift[SEGS-2:0], pixel}; // [RULE_18]
      next_s.dotIdx = (s.dotIdx == DOT_LAST) ? 3'h0 : 3'(s.dotIdx + 3'h1);
      if (s.dotIdx == DOT_LAST) next_s.posIdx = 4'(s.posIdx + 4'h1); // [RULE_08]
      if (transfer)
      begin
         next_s.segHold = {s.segShift[SEGS-2:0], pixel}; // [RULE_18]
         next_s.comSel = COMMONS'(1) << s.comIdx; // [RULE_17]
         next_s.comIdx = (s.comIdx == ICON_COM) ? 5'h00 : 5'(s.comIdx + 5'h01);
         if (s.comIdx == ICON_COM) next_s.frameCnt = 4'(s.frameCnt + 4'h1);
      end
   end

   // Registers the state; memories clear to zero.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s <= '0;
         s.ctrl <= CTRL_RESET;
      end
      else
         s <= next_s;
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   logic busyNow;
   logic [6:0] insArg;
   logic glyphStep;
   assign busyNow = (s.busyCnt != 8'h00);
   assign insArg = avReq.writedata[6:0];
   assign glyphStep = done && avReq.write && avReq.address == REG_DATA && s.target == TGT_GLYPH && s.ctrl[CTRL_INC];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_busy_blocks: assert property (avReq.write && hostReg && busyNow |-> avRsp.waitrequest) // [RULE_01]
      else $error("Write accepted while busy.");
   a_busy_starts: assert property (done && avReq.write && avReq.address == REG_INSTR |=> busyNow [*2]) // [RULE_01]
      else $error("Busy not held after instruction.");
   a_status_read: assert property (avReq.read && avReq.address == REG_INSTR && !s.rspRdy && !serialMode
      |=> avRsp.readdata[7] == $past(busyNow) && avRsp.readdata[6:0] == $past(s.ptr)) // [RULE_02] [RULE_06]
      else $error("Status word wrong.");
   a_ptr_load: assert property (done && avReq.write && avReq.address == REG_INSTR && avReq.writedata[7]
      |=> s.ptr == $past(insArg) && s.target == TGT_CHAR) // [RULE_04]
      else $error("Pointer not loaded.");
   a_ptr_step: assert property (glyphStep |=> s.ptr[5:0] == 6'($past(s.ptr) + 7'h01)) // [RULE_05]
      else $error("Pointer not stepped.");
   a_line_wrap: assert property (done && avReq.write && avReq.address == REG_DATA && s.target == TGT_CHAR
      && twoLine && s.ctrl[CTRL_INC] && s.ptr == LINE1_END |=> s.ptr == LINE2_BASE) // [RULE_09]
      else $error("Line one end did not jump to line two.");
   a_serial_noread: assert property (done && avReq.read && hostReg && serialMode |-> avRsp.readdata == 32'h0) // [RULE_16]
      else $error("Read data in serial mode.");
   a_com_onehot: assert property ($onehot0(s.comSel)) // [RULE_17]
      else $error("More than one common selected.");
   a_latch_hold: assert property (!transfer |=> $stable(s.segHold) && $stable(s.comSel)) // [RULE_18]
      else $error("Holding latch changed mid line.");

   c_status_busy: cover property (done && avReq.read && avReq.address == REG_INSTR && busyNow);
   c_write_blocked: cover property (blocked ##1 blocked ##1 !blocked);
   c_icon_line: cover property (transfer && s.comIdx == ICON_COM);
endmodule

// *** sim/lcdma_host.sv ***
// Host processor model that drives the register bus of the display core.
`timescale 1ns/1ps
module lcdma_host
(
   input wire logic clk,
   output lcdma_pkg::lcdma_avreq_t avReq,
   input wire lcdma_pkg::lcdma_avrsp_t avRsp
);
   import lcdma_pkg::*;

   // The bus stays idle until the first request.
   initial avReq = '0;

   // One transfer: the request is held until a rising edge samples waitrequest low.
   // Read data is taken at that same edge and the request is released right after it.
   task automatic xfer(input logic [3:0] adr, input logic wr, input logic [7:0] wd,
      output logic [31:0] rd, output int waits);
      waits = 0;
      @(posedge clk);
      avReq.address <= adr;
      avReq.read <= !wr;
      avReq.write <= wr;
      avReq.writedata <= {24'h000000, wd};
      @(posedge clk);
      while (avRsp.waitrequest !== 1'b0 && waits < 2000)
      begin
         waits++;
         @(posedge clk);
      end
      rd = avRsp.readdata;
      avReq <= '0;
   endtask

   // Writes a register once a status read shows the busy indicator low.
   task automatic put(input logic [3:0] adr, input logic [7:0] wd);
      logic [31:0] st;
      int w;
      st = 32'h00000080;
      while (st[STAT_BUSY_BIT] === 1'b1)
      begin
         xfer(REG_INSTR, 1'b0, 8'h00, st, w);
      end
      xfer(adr, 1'b1, wd, st, w);
   endtask
endmodule

// *** sim/test_char_lcd_memory_address_logic.sv ***
// Self-checking testbench of the character display memory and addressing core.
`timescale 1ns/1ps
module test_char_lcd_memory_address_logic;
   import lcdma_pkg::*;

   typedef struct packed
   {
      logic [7:0] ins;
      logic [7:0] dat;
      logic [6:0] ptr;
   } lcdma_row_t;

   // Each row: address instruction, data written, pointer expected after the write.
   localparam lcdma_row_t ROWS [7] = '{
      '{8'h80, 8'h5A, 7'h01},
      '{8'hA7, 8'h08, 7'h40},
      '{8'hE7, 8'h33, 7'h00},
      '{8'hCF, 8'h77, 7'h50},
      '{8'h7F, 8'h1C, 7'h00},
      '{8'h2F, 8'h15, 7'h00},
      '{8'h40, 8'h1F, 7'h01}};

   logic clk;
   logic nrst;
   logic [1:0] glyphOptPins;
   lcdma_avreq_t avReq;
   lcdma_avrsp_t avRsp;
   logic [COMMONS-1:0] comOut;
   logic [SEGS-1:0] segOut;
   logic [31:0] v;
   int w;
   int errors;
   int checked;
   int cycles;

   lcdma_core lcdma_core_i (.clk(clk), .nrst(nrst), .avReq(avReq), .avRsp(avRsp),
      .glyphOptPins(glyphOptPins), .comOut(comOut), .segOut(segOut));
   lcdma_host lcdma_host_i (.clk(clk), .avReq(avReq), .avRsp(avRsp));

   // ***************************************************************
   // Clock, timeout and reporting
   // ***************************************************************
   always #2.5 clk = ~clk;

   // Cuts a hang short once the run is far past its expected length.
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         errors++;
         finish_test;
      end
   end

   task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic chkSeg(input string what, input logic [4:0] exp, input logic [4:0] got);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic rd(input logic [3:0] adr, output logic [31:0] d);
      int n;
      lcdma_host_i.xfer(adr, 1'b0, 8'h00, d, n);
   endtask

   // Waits for the icon common, then the first common, and checks the two leftmost characters.
   task automatic scanChk(input logic [4:0] want0, input logic [4:0] want1);
      int n;
      n = 0;
      while (comOut[16] !== 1'b1 && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      while (comOut[0] !== 1'b1 && n < 6000)
      begin
         @(negedge clk);
         n++;
      end
      chkWord("common count", 32'h1, $countones(comOut));
      chkSeg("position 1 row 1", want0, segOut[79:75]);
      chkSeg("position 2 row 1", want1, segOut[74:70]);
   endtask

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      clk = 1'b0;
      nrst = 1'b0;
      glyphOptPins = 2'h0;
      errors = 0;
      checked = 0;
      cycles = 0;
      repeat (10) @(posedge clk);
      chkWord("commons in reset", 32'h0, {15'h0, comOut});
      chkWord("segments in reset", 32'h0, {31'h0, |segOut});
      nrst <= 1'b1;
      rd(REG_INSTR, v);
      chkWord("status after reset", 32'h0, v);
      rd(REG_CTRL, v);
      chkWord("control after reset", {24'h0, CTRL_RESET}, v);
      $display("test reset done");
      // Table of ordinary accesses: store, status with busy, then read back.
      foreach (ROWS[i])
      begin
         lcdma_host_i.put(REG_INSTR, ROWS[i].ins);
         lcdma_host_i.put(REG_DATA, ROWS[i].dat);
         rd(REG_INSTR, v);
         chkWord("status", {24'h0, 1'b1, ROWS[i].ptr}, v);
         lcdma_host_i.put(REG_INSTR, ROWS[i].ins);
         rd(REG_DATA, v);
         chkWord("data", {24'h0, ROWS[i].dat}, v);
      end
      $display("test table done");
      // Downward stepping across the line gap and over the one-line wrap.
      lcdma_host_i.put(REG_CTRL, 8'h01);
      lcdma_host_i.put(REG_INSTR, 8'hC0);
      lcdma_host_i.put(REG_DATA, 8'h11);
      rd(REG_INSTR, v);
      chkWord("status down", 32'hA7, v);
      lcdma_host_i.put(REG_CTRL, 8'h00);
      lcdma_host_i.put(REG_INSTR, 8'h80);
      lcdma_host_i.put(REG_DATA, 8'h11);
      rd(REG_INSTR, v);
      chkWord("status one line", 32'hCF, v);
      lcdma_host_i.put(REG_CTRL, 8'h03);
      $display("test downward done");
      // A data write straight after an instruction is held off while busy.
      lcdma_host_i.xfer(REG_INSTR, 1'b1, 8'h80, v, w);
      lcdma_host_i.xfer(REG_DATA, 1'b1, 8'h08, v, w);
      chkWord("held write", 32'h1, {31'h0, w >= 4});
      $display("test busy done");
      // Serial host mode gives no status or data read path and reads do not step the pointer.
      lcdma_host_i.put(REG_CTRL, 8'h13);
      rd(REG_INSTR, v);
      chkWord("serial status", 32'h0, v);
      rd(REG_DATA, v);
      chkWord("serial data", 32'h0, v);
      lcdma_host_i.put(REG_CTRL, 8'h03);
      rd(REG_INSTR, v);
      chkWord("pointer after serial", 32'h01, v);
      lcdma_host_i.put(4'hC, 8'hAA);
      rd(4'hC, v);
      chkWord("unmapped", 32'h0, v);
      $display("test serial done");
      // Panel scan: user glyph alias, blank fixed codes, option pins and shift.
      scanChk(5'h1F, 5'h1F);
      lcdma_host_i.put(REG_INSTR, 8'h80);
      lcdma_host_i.put(REG_DATA, 8'hFF);
      scanChk(5'h00, 5'h1F);
      @(posedge clk);
      glyphOptPins <= 2'h3;
      scanChk(5'h1F, 5'h1F);
      @(posedge clk);
      glyphOptPins <= 2'h0;
      lcdma_host_i.put(REG_INSTR, 8'h19);
      scanChk(5'h1F, 5'h00);
      lcdma_host_i.put(REG_INSTR, 8'h18);
      scanChk(5'h00, 5'h1F);
      $display("test scan done");
      finish_test;
   end
endmodule
